/* logic/sram_host_ctrl.sv */
// Module: host controller driving an asynchronous 1M x 16 static memory
`timescale 1ns/1ps
module sram_host_ctrl
	import sram_host_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// Request side
	input  wire logic              req_valid,
	input  wire mem_req_t          req,
	output logic                   req_ready,
	output logic                   rsp_valid,
	output logic      [DATA_W-1:0] rsp_rdata,
	// Memory pins
	output logic                   chip_select_n,
	output logic                   output_enable_n,
	output logic                   write_strobe_n,
	output logic                   low_byte_select_n,
	output logic                   high_byte_select_n,
	output logic      [ADDR_W-1:0] mem_addr,
	output logic      [DATA_W-1:0] dq_out,
	output logic      [DATA_W-1:0] dq_oe,
	input  wire logic [DATA_W-1:0] dq_in
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		phase_t              phase;
		logic [CNT_W-1:0]    cnt;
		pin_out_t            pins;
		logic                ready;
		logic                rsp_valid;
		logic [DATA_W-1:0]   rdata;
	} ctrl_state_t;

	ctrl_state_t state_reg;
	ctrl_state_t state_next;
	logic [DATA_W-1:0] dq_sync;

	sram_pin_sync u_sync (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.pin_in   (dq_in),
		.pin_sync (dq_sync)
	);

	function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] lane_n);
		lane_mask = {{LANE_W{~lane_n[1]}}, {LANE_W{~lane_n[0]}}};
	endfunction

	function automatic pin_out_t idle_pins();
		pin_out_t p;
		p = '0;
		p.chip_select_n = 1'b1;
		p.output_enable_n = 1'b1;
		p.write_strobe_n = 1'b1;
		p.low_byte_select_n = 1'b1;
		p.high_byte_select_n = 1'b1;
		idle_pins = p;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.rsp_valid = 1'b0;
		case (state_reg.phase)
			ST_IDLE: begin
				state_next.pins = idle_pins();
				state_next.ready = 1'b1;
				if (req_valid && state_reg.ready) begin
					state_next.ready = 1'b0;
					state_next.pins.chip_select_n = 1'b0;
					state_next.pins.addr = req.addr;
					state_next.pins.low_byte_select_n = req.lane_n[0];
					state_next.pins.high_byte_select_n = req.lane_n[1];
					state_next.pins.write_strobe_n = ~req.write;
					state_next.pins.output_enable_n = req.write;
					state_next.pins.dq_out = req.wdata;
					// Output enable stays high in writes so the bus is free at once
					state_next.pins.dq_oe = req.write ? ~req.lane_n : 2'b00;
					// Extra read cycle so the synchroniser holds settled data
					state_next.cnt = req.write ? STROBE_CYC : CNT_W'(READ_CYC_I + 1);
					state_next.phase = req.write ? ST_WRITE : ST_READ;
				end
			end
			ST_READ: begin
				state_next.pins.write_strobe_n = 1'b1;
				if (state_reg.cnt != '0) begin
					state_next.cnt = state_reg.cnt - 1'b1;
				end else begin
					state_next.rdata = dq_sync & lane_mask({state_reg.pins.high_byte_select_n,
						state_reg.pins.low_byte_select_n});
					state_next.rsp_valid = 1'b1;
					state_next.pins = idle_pins();
					state_next.cnt = TURN_CYC;
					state_next.phase = ST_TURN;
				end
			end
			ST_WRITE: begin
				if (state_reg.cnt != '0) begin
					state_next.cnt = state_reg.cnt - 1'b1;
				end else begin
					// Strobe rises first; data, address, select held one more cycle
					state_next.pins.write_strobe_n = 1'b1;
					state_next.rsp_valid = 1'b1;
					state_next.cnt = TURN_CYC;
					state_next.phase = ST_TURN;
				end
			end
			ST_TURN: begin
				state_next.pins = idle_pins();
				if (state_reg.cnt != '0) begin
					state_next.cnt = state_reg.cnt - 1'b1;
				end else begin
					state_next.ready = 1'b1;
					state_next.phase = ST_IDLE;
				end
			end
			default: begin
				state_next.phase = ST_IDLE;
				state_next.pins = idle_pins();
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg <= '{phase: ST_IDLE, cnt: '0, pins: '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
				'0, '0, 2'b00}, ready: 1'b0, rsp_valid: 1'b0, rdata: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign req_ready = state_reg.ready;
	assign rsp_valid = state_reg.rsp_valid;
	assign rsp_rdata = state_reg.rdata;
	assign chip_select_n = state_reg.pins.chip_select_n;
	assign output_enable_n = state_reg.pins.output_enable_n;
	assign write_strobe_n = state_reg.pins.write_strobe_n;
	assign low_byte_select_n = state_reg.pins.low_byte_select_n;
	assign high_byte_select_n = state_reg.pins.high_byte_select_n;
	assign mem_addr = state_reg.pins.addr;
	assign dq_out = state_reg.pins.dq_out;
	assign dq_oe = {{LANE_W{state_reg.pins.dq_oe[1]}}, {LANE_W{state_reg.pins.dq_oe[0]}}};

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_write_overlap: assert property (
		(!write_strobe_n) |-> !chip_select_n)
		else $error("write strobe low without chip select");
	a_strobe_first: assert property (
		$rose(write_strobe_n) |-> !chip_select_n)
		else $error("chip select rose before write strobe");
	a_data_hold: assert property (
		$rose(write_strobe_n) |-> $stable(dq_out) &&
			(dq_oe == lane_mask({high_byte_select_n, low_byte_select_n})))
		else $error("write data not held at strobe rise");
	a_float_idle: assert property (
		chip_select_n |-> (dq_oe == '0))
		else $error("host drives bus while deselected");
	a_read_lanes: assert property (
		(!output_enable_n && write_strobe_n) |-> (dq_oe == '0))
		else $error("host drives bus during read");
	a_write_lanes: assert property (
		(!write_strobe_n) |-> dq_oe == {{LANE_W{!high_byte_select_n}}, {LANE_W{!low_byte_select_n}}})
		else $error("write lanes do not match selects");
	a_strobe_width: assert property (
		$fell(write_strobe_n) |-> !write_strobe_n [*2])
		else $error("write strobe pulse too short");
	a_no_contention: assert property (
		(!output_enable_n) |-> (dq_oe == '0))
		else $error("bus driven with output enable low");
	a_read_strobe: assert property (
		$fell(output_enable_n) |-> write_strobe_n [*3])
		else $error("write strobe moved during read");
	a_resp_bound: assert property (
		(req_valid && req_ready) |-> ##[2:8] rsp_valid)
		else $error("no response in time");

	c_read: cover property ($fell(output_enable_n));
	c_write: cover property ($rose(write_strobe_n));
	c_low_byte: cover property (!write_strobe_n && high_byte_select_n);
	c_high_read: cover property (!output_enable_n && low_byte_select_n);
endmodule

/* include/sram_host_pkg.sv */
// Package: constants, types and timing for the static memory host controller
package sram_host_pkg;
	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;
	// ------------------------------------------------------------
	// Timing in ns and in cycles of clk_sys
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int READ_CYCLE_NS = 10;
	localparam int ADDR_SETUP_NS = 7;
	localparam int STROBE_TO_FLOAT_DELAY_NS = 5;
	localparam int DATA_SETUP_TIME_NS = 5;
	localparam int BUS_TURN_NS = 5;
	localparam int CNT_W = 4;
	localparam int READ_CYC_I = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int FLOAT_CYC_I = (STROBE_TO_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC_I = (DATA_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WSETUP_CYC_I = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TURN_CYC_I = (BUS_TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [CNT_W-1:0] READ_CYC = CNT_W'(READ_CYC_I);
	localparam logic [CNT_W-1:0] FLOAT_CYC = CNT_W'(FLOAT_CYC_I);
	localparam logic [CNT_W-1:0] STROBE_CYC =
		CNT_W'((FLOAT_CYC_I + SETUP_CYC_I > WSETUP_CYC_I) ?
			FLOAT_CYC_I + SETUP_CYC_I : WSETUP_CYC_I);
	localparam logic [CNT_W-1:0] TURN_CYC = CNT_W'(TURN_CYC_I);
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_WRITE, ST_TURN} phase_t;

	typedef struct packed {
		logic                write;
		logic [ADDR_W-1:0]   addr;
		logic [1:0]          lane_n;
		logic [DATA_W-1:0]   wdata;
	} mem_req_t;

	typedef struct packed {
		logic                chip_select_n;
		logic                output_enable_n;
		logic                write_strobe_n;
		logic                low_byte_select_n;
		logic                high_byte_select_n;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   dq_out;
		logic [1:0]          dq_oe;
	} pin_out_t;
endpackage

/* logic/sram_pin_sync.sv */
// Module: two-stage synchroniser for the returning data pins
`timescale 1ns/1ps
module sram_pin_sync
	import sram_host_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// Data
	input  wire logic [DATA_W-1:0] pin_in,
	output logic      [DATA_W-1:0] pin_sync
);
	logic [DATA_W-1:0] stage1_reg;
	logic [DATA_W-1:0] stage2_reg;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end else begin
			stage1_reg <= pin_in;
			stage2_reg <= stage1_reg;
		end
	end

	assign pin_sync = stage2_reg;
endmodule

/* tb/sram_mem_model.sv */
// Behavioural model of the asynchronous 1M x 16 static memory
`timescale 1ns/1ps
module sram_mem_model
	import sram_host_pkg::*;
(
	// Control pins
	input  wire logic              chip_select_n,
	input  wire logic              output_enable_n,
	input  wire logic              write_strobe_n,
	input  wire logic              low_byte_select_n,
	input  wire logic              high_byte_select_n,
	input  wire logic [ADDR_W-1:0] mem_addr,
	// Data bus
	input  wire logic [DATA_W-1:0] dq_out,
	input  wire logic [DATA_W-1:0] dq_oe,
	output logic      [DATA_W-1:0] dq_bus,
	output logic                   clash
);
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	logic [DATA_W-1:0] rd;
	logic [DATA_W-1:0] drv;
	logic [DATA_W-1:0] w;
	logic              wr_act;
	logic              rd_on;
	assign wr_act = !chip_select_n && !write_strobe_n;
	assign rd_on = !chip_select_n && !output_enable_n && write_strobe_n;
	assign drv = {{LANE_W{rd_on && !high_byte_select_n}}, {LANE_W{rd_on && !low_byte_select_n}}};
	// Floating lanes show the inverse so a stale value never passes
	assign dq_bus = (dq_oe & dq_out) | (~dq_oe & drv & rd) | (~dq_oe & ~drv & ~rd);
	assign clash = |(dq_oe & drv);
	always @* begin
		rd = mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
	end
	// Store at the first rising strobe or select
	always @(negedge wr_act) begin
		w = mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
		if (!low_byte_select_n) w[7:0] = dq_bus[7:0];
		if (!high_byte_select_n) w[15:8] = dq_bus[15:8];
		mem[mem_addr] = w;
	end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the static memory host controller
`timescale 1ns/1ps
module tb_top
	import sram_host_pkg::*;
;
	logic              clk_sys;
	logic              rst_n;
	logic              req_valid;
	mem_req_t          req;
	logic              req_ready;
	logic              rsp_valid;
	logic [DATA_W-1:0] rsp_rdata;
	logic              cs_n, oe_n, we_n, lb_n, hb_n, clash, pwe;
	logic [ADDR_W-1:0] mem_addr;
	logic [DATA_W-1:0] dq_out, dq_oe, dq_bus, pdq, r;
	int                error_cnt, n_checks, lo_cnt;

	sram_host_ctrl u_sram_host_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.chip_select_n(cs_n), .output_enable_n(oe_n), .write_strobe_n(we_n),
		.low_byte_select_n(lb_n), .high_byte_select_n(hb_n), .mem_addr(mem_addr),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_bus));
	sram_mem_model u_sram_mem_model (.chip_select_n(cs_n), .output_enable_n(oe_n),
		.write_strobe_n(we_n), .low_byte_select_n(lb_n), .high_byte_select_n(hb_n),
		.mem_addr(mem_addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_bus(dq_bus), .clash(clash));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [DATA_W-1:0] got, exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic do_op(input logic wr, input logic [19:0] a, input logic [1:0] ln,
		input logic [15:0] wd, output logic [15:0] rd);
		int n;
		int m;
		n = 0;
		m = 0;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req <= '{wr, a, ln, wd};
		do begin @(posedge clk_sys); n++; end while (req_ready !== 1'b1 && n < 20);
		req_valid <= 1'b0;
		if (n < 20) begin
			do begin @(posedge clk_sys); #1; m++; end while (rsp_valid !== 1'b1 && m < 20);
		end
		if (n >= 20 || m >= 20) begin
			error_cnt++;
			$display("[ERR] %0t no answer", $time);
			finish_test();
		end else begin
			check(16'(m), wr ? 16'h0003 : 16'h0004, "answer latency");
			rd = rsp_rdata;
		end
	endtask

	// ------------------------------------------------------------
	// Pin monitor
	// ------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (rst_n) begin
			if (clash || (!oe_n && !we_n)) begin
				error_cnt++;
				$display("[ERR] %0t bus drive conflict", $time);
			end
			if (we_n && !pwe) begin
				check(16'(lo_cnt * CLK_PERIOD_NS >= STROBE_TO_FLOAT_DELAY_NS + DATA_SETUP_TIME_NS),
					16'h0001, "strobe width");
				check(dq_out, pdq, "data hold");
			end
		end
		lo_cnt = we_n ? 0 : lo_cnt + 1;
		pwe = we_n;
		pdq = dq_out;
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check({11'h000, cs_n, oe_n, we_n, lb_n, hb_n}, 16'h001F, "idle pins");
		check(dq_oe, 16'h0000, "idle drive");
		$display("test reset done");
	endtask

	task automatic t_full();
		do_op(1'b1, 20'hFFFFF, 2'b00, 16'hA55A, r);
		do_op(1'b1, 20'h00000, 2'b00, 16'h1234, r);
		do_op(1'b0, 20'hFFFFF, 2'b00, 16'h0000, r);
		check(r, 16'hA55A, "top word");
		do_op(1'b0, 20'h00000, 2'b00, 16'h0000, r);
		check(r, 16'h1234, "bottom word");
		$display("test full done");
	endtask

	task automatic t_lanes();
		logic [1:0]  ln [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
		logic [15:0] wd [4] = '{16'hBEEF, 16'h1122, 16'h3344, 16'h5566};
		logic [15:0] we [4] = '{16'hBEEF, 16'hBE22, 16'h3322, 16'h3322};
		logic [15:0] re [4] = '{16'h3322, 16'h0022, 16'h3300, 16'h0000};
		for (int i = 0; i < 4; i++) begin
			do_op(1'b1, 20'h00ABC, ln[i], wd[i], r);
			do_op(1'b0, 20'h00ABC, 2'b00, 16'h0000, r);
			check(r, we[i], "lane write");
		end
		for (int i = 0; i < 4; i++) begin
			do_op(1'b0, 20'h00ABC, ln[i], 16'h0000, r);
			check(r, re[i], "lane read");
		end
		$display("test lanes done");
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		error_cnt = 0;
		n_checks = 0;
		lo_cnt = 0;
		pwe = 1'b1;
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		t_reset();
		t_full();
		t_lanes();
		finish_test();
	end
endmodule
